/* File: shared/qei_pkg.sv */
// Purpose: Constants and types for the quadrature encoder interface
// Assumes: APB slave, 32-bit data, word aligned registers
// Notes: Control field layout follows the control register
package qei_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [11:0] QEI_OFF_CTL = 12'h000;
	localparam logic [11:0] QEI_OFF_STAT = 12'h004;
	localparam logic [11:0] QEI_OFF_POS = 12'h008;
	localparam logic [11:0] QEI_OFF_MAXPOS = 12'h00C;
	localparam logic [11:0] QEI_OFF_LOAD = 12'h010;
	localparam logic [11:0] QEI_OFF_TIME = 12'h014;
	localparam logic [11:0] QEI_OFF_COUNT = 12'h018;
	localparam logic [11:0] QEI_OFF_SPEED = 12'h01C;
	localparam logic [11:0] QEI_OFF_INTEN = 12'h020;
	localparam logic [11:0] QEI_OFF_RIS = 12'h024;
	localparam logic [11:0] QEI_OFF_ISC = 12'h028;
	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int QEI_CTL_W = 12;
	localparam logic [11:0] QEI_CTL_RST = 12'h000;
	localparam logic [31:0] QEI_ZERO = 32'h0000_0000;
	localparam logic [31:0] QEI_ONE = 32'h0000_0001;
	localparam int QEI_INT_ERR = 0;
	localparam int QEI_INT_DIR = 1;
	localparam int QEI_INT_TMR = 2;
	localparam int QEI_INT_IDX = 3;
	localparam logic [3:0] QEI_INT_RST = 4'h0;
	localparam logic [7:0] QEI_DIV_RST = 8'h00;

	typedef struct packed {
		logic invert_index;
		logic invert_phase_b;
		logic invert_phase_a;
		logic [2:0] velocity_predivide;
		logic velocity_enable;
		logic reset_mode;
		logic capture_mode;
		logic signal_mode;
		logic swap;
		logic enable;
	} qei_ctl_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} qei_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} qei_apb_rsp_t;

	typedef struct packed {
		logic phase_a;
		logic phase_b;
		logic index;
	} qei_pins_t;
endpackage : qei_pkg

/* File: core/qei_core.sv */
// Purpose: Quadrature encoder position, direction and velocity block
// Assumes: Single clock pclk, APB register access
// Notes: Encoder pins are asynchronous and synchronised inside
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
// Summary of operation
// R01: Velocity works only with position enabled
// R02: Swap exchanges phases before all decoding
// R03: signal_mode picks quadrature or clock/direction
// R04: capture_mode counts phase_a or both edges
// R05: Increment when phase_a leads phase_b
// R06: Decrement when phase_b leads phase_a
// R07: Same-phase edge pair flags direction change
// R08: reset_mode 0 clears position on index
// R09: Backward from zero loads max_position
// R10: reset_mode 1 bounds position, ignores index
// R11: Velocity counts edges with position settings
// R12: Period end copies count, clears, restarts
// R13: Timer counts down, reloads from timer_load
// R14: Four interrupts with mask, status, clear
// R15: Encoder gives two phases 90 degrees apart
// R16: Encoder gives step clock and direction level
// R17: Decoding starts only after enable set
// R18: Predivide velocity edges by power of two
// R19: Both phases changing is phase error
// R20: Invert each input before other processing
// R21: Clock mode steps on rising edge, direction
// R22: Inputs pass two synchroniser flip-flops
// R23: Reset zeroes counters, flags, disables functions
module qei_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire qei_pkg::qei_apb_req_t apb_req,
	output qei_pkg::qei_apb_rsp_t apb_rsp,
	input wire qei_pkg::qei_pins_t pins,
	output logic irq,
	output logic direction
);
	import qei_pkg::*;

	// ****************************************
	// State
	// ****************************************
	qei_ctl_t ctl_q, ctl_d;
	logic [31:0] pos_q, pos_d, max_q, max_d, load_q, load_d;
	logic [31:0] tmr_q, tmr_d, cnt_q, cnt_d, spd_q, spd_d;
	logic [3:0] inten_q, inten_d, ris_q, ris_d;
	logic [2:0] s1_q, s2_q, s3_q;
	logic [7:0] div_q, div_d;
	logic dir_q, dir_d, err_q, err_d;
	logic last_ph_q, last_ph_d;
	logic [1:0] pair_q, pair_d;
	qei_apb_rsp_t rsp_q, rsp_d;
	logic irq_q;

	// ****************************************
	// Input synchroniser and conditioning
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
			s3_q <= 3'h0;
		end else begin
			s1_q <= {pins.phase_a, pins.phase_b, pins.index}; // [R22]
			s2_q <= s1_q; // [R22]
			s3_q <= s2_q;
		end
	end

	logic ca, cb, ci, pa, pb, pi;
	logic ea, eb, idx_rise, step, up, both;
	logic [2:0] cur, prv;
	always_comb begin
		// Invert first so swap sees corrected polarity
		cur = s2_q ^ {ctl_q.invert_phase_a, ctl_q.invert_phase_b, ctl_q.invert_index}; // [R20]
		prv = s3_q ^ {ctl_q.invert_phase_a, ctl_q.invert_phase_b, ctl_q.invert_index}; // [R20]
		ca = ctl_q.swap ? cur[1] : cur[2]; // [R02]
		cb = ctl_q.swap ? cur[2] : cur[1]; // [R02]
		pa = ctl_q.swap ? prv[1] : prv[2];
		pb = ctl_q.swap ? prv[2] : prv[1];
		ci = cur[0];
		pi = prv[0];
		ea = ca ^ pa;
		eb = cb ^ pb;
		idx_rise = ci & ~pi;
		both = ea & eb;
		step = 1'b0;
		up = 1'b0;
		if (ctl_q.enable) begin // [R17]
			if (ctl_q.signal_mode) begin // [R03]
				step = ca & ~pa; // [R21]
				up = cb; // [R21]
			end else if (!both) begin // [R19]
				step = ea | (ctl_q.capture_mode & eb); // [R04]
				// Gray code: phase_a leading means a differs from b after its edge
				up = ea ? (ca ^ cb) : ~(ca ^ cb); // [R05] [R06]
			end
		end
	end

	// ****************************************
	// Position, direction, velocity
	// ****************************************
	logic ev_err, ev_dir, ev_tmr, ev_idx;
	always_comb begin
		pos_d = pos_q;
		dir_d = dir_q;
		err_d = err_q;
		last_ph_d = last_ph_q;
		pair_d = pair_q;
		tmr_d = tmr_q;
		cnt_d = cnt_q;
		spd_d = spd_q;
		div_d = div_q;
		ev_err = 1'b0;
		ev_dir = 1'b0;
		ev_tmr = 1'b0;
		ev_idx = 1'b0;
		if (ctl_q.enable) begin
			ev_idx = idx_rise;
			if (!ctl_q.signal_mode && both) begin
				ev_err = 1'b1; // [R19]
				err_d = 1'b1;
			end
			// Two edges on one phase with none on the other
			if (!ctl_q.signal_mode && !both && (ea | eb)) begin
				if (ea == (last_ph_q == 1'b0) && pair_q == 2'h1) begin
					ev_dir = 1'b1; // [R07]
					pair_d = 2'h0;
				end else if (ea == (last_ph_q == 1'b0)) begin
					pair_d = 2'h1;
				end else begin
					pair_d = 2'h1;
				end
				last_ph_d = eb;
			end
			if (step) begin
				dir_d = ~up;
				if (up) begin
					pos_d = (pos_q >= max_q) ? QEI_ZERO : pos_q + QEI_ONE; // [R05] [R10]
				end else begin
					pos_d = (pos_q == QEI_ZERO) ? max_q : pos_q - QEI_ONE; // [R06] [R09]
				end
			end
			if (idx_rise && !ctl_q.reset_mode) begin
				pos_d = QEI_ZERO; // [R08]
			end
			if (ctl_q.velocity_enable) begin // [R01]
				if (step) begin // [R11]
					div_d = div_q + 8'h01;
					// Predivide: pass one edge per 2^n edges, phase runs free
					if ((div_d & ((8'h01 << ctl_q.velocity_predivide) - 8'h01)) == 8'h00) begin
						cnt_d = cnt_q + QEI_ONE; // [R18]
					end
				end
				if (tmr_q == QEI_ZERO) begin
					tmr_d = load_q; // [R13]
					spd_d = cnt_d; // [R12]
					cnt_d = QEI_ZERO; // [R12]
					ev_tmr = 1'b1; // [R13]
				end else begin
					tmr_d = tmr_q - QEI_ONE; // [R13]
				end
			end
		end
	end

	// ****************************************
	// APB slave
	// ****************************************
	logic wr, rd;
	always_comb begin
		ctl_d = ctl_q;
		max_d = max_q;
		load_d = load_q;
		inten_d = inten_q;
		rsp_d = '0;
		rsp_d.pready = 1'b1;
		wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
		rd = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
		// Events set after clear so the set wins
		ris_d = ris_q;
		if (wr && apb_req.paddr == QEI_OFF_ISC) begin
			ris_d = ris_q & ~apb_req.pwdata[3:0]; // [R14]
		end
		ris_d[QEI_INT_ERR] = ris_d[QEI_INT_ERR] | ev_err; // [R14]
		ris_d[QEI_INT_DIR] = ris_d[QEI_INT_DIR] | ev_dir;
		ris_d[QEI_INT_TMR] = ris_d[QEI_INT_TMR] | ev_tmr;
		ris_d[QEI_INT_IDX] = ris_d[QEI_INT_IDX] | ev_idx;
		if (wr) begin
			case (apb_req.paddr)
				QEI_OFF_CTL: ctl_d = qei_ctl_t'(apb_req.pwdata[11:0]); // [R17]
				QEI_OFF_MAXPOS: max_d = apb_req.pwdata;
				QEI_OFF_LOAD: load_d = apb_req.pwdata;
				QEI_OFF_INTEN: inten_d = apb_req.pwdata[3:0];
				default: ;
			endcase
		end
		rsp_d.prdata = rsp_q.prdata;
		if (rd) begin
			case (apb_req.paddr)
				QEI_OFF_CTL: rsp_d.prdata = {20'h00000, ctl_q};
				QEI_OFF_STAT: rsp_d.prdata = {30'h0000000, dir_q, err_q};
				QEI_OFF_POS: rsp_d.prdata = pos_q;
				QEI_OFF_MAXPOS: rsp_d.prdata = max_q;
				QEI_OFF_LOAD: rsp_d.prdata = load_q;
				QEI_OFF_TIME: rsp_d.prdata = tmr_q;
				QEI_OFF_COUNT: rsp_d.prdata = cnt_q;
				QEI_OFF_SPEED: rsp_d.prdata = spd_q;
				QEI_OFF_INTEN: rsp_d.prdata = {28'h0000000, inten_q};
				QEI_OFF_RIS: rsp_d.prdata = {28'h0000000, ris_q};
				QEI_OFF_ISC: rsp_d.prdata = {28'h0000000, ris_q & inten_q};
				default: rsp_d.prdata = QEI_ZERO;
			endcase
		end
		rsp_d.pslverr = 1'b0;
	end

	// Position write from software is taken outside the decode path
	logic pos_wr;
	assign pos_wr = wr && (apb_req.paddr == QEI_OFF_POS);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= qei_ctl_t'(QEI_CTL_RST); // [R23]
			pos_q <= QEI_ZERO; // [R23]
			max_q <= QEI_ZERO;
			load_q <= QEI_ZERO;
			tmr_q <= QEI_ZERO;
			cnt_q <= QEI_ZERO;
			spd_q <= QEI_ZERO;
			inten_q <= QEI_INT_RST;
			ris_q <= QEI_INT_RST;
			div_q <= QEI_DIV_RST;
			dir_q <= 1'b0;
			err_q <= 1'b0;
			last_ph_q <= 1'b0;
			pair_q <= 2'h0;
			rsp_q <= '0;
			irq_q <= 1'b0;
		end else begin
			ctl_q <= ctl_d;
			pos_q <= pos_wr ? apb_req.pwdata : pos_d;
			max_q <= max_d;
			load_q <= load_d;
			tmr_q <= tmr_d;
			cnt_q <= cnt_d;
			spd_q <= spd_d;
			inten_q <= inten_d;
			ris_q <= ris_d;
			div_q <= div_d;
			dir_q <= dir_d;
			err_q <= err_d;
			last_ph_q <= last_ph_d;
			pair_q <= pair_d;
			rsp_q <= rsp_d;
			irq_q <= |(ris_d & inten_d); // [R14]
		end
	end

	assign apb_rsp = '{pready: 1'b1, pslverr: 1'b0, prdata: rsp_q.prdata};
	assign irq = irq_q;
	assign direction = dir_q;

	// ****************************************
	// Checks
	// ****************************************
	a_vel_needs_en: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
		!ctl_q.enable |=> $stable(cnt_q) && $stable(spd_q))
		else $error("velocity moved while disabled");
	a_pos_idle: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
		(!ctl_q.enable && !pos_wr) |=> $stable(pos_q))
		else $error("position moved while disabled");
	a_idx_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
		(ctl_q.enable && !ctl_q.reset_mode && idx_rise && !pos_wr) |=> pos_q == QEI_ZERO)
		else $error("index did not clear position");
	a_wrap_back: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
		(step && !up && pos_q == QEI_ZERO && !pos_wr && !(idx_rise && !ctl_q.reset_mode))
		|=> pos_q == $past(max_q))
		else $error("backward wrap did not load max");
	a_pos_inc: assert property (@(posedge pclk) disable iff (!presetn) // [R05]
		(step && up && pos_q < max_q && !pos_wr && !(idx_rise && !ctl_q.reset_mode))
		|=> pos_q == $past(pos_q) + QEI_ONE)
		else $error("position did not increment");
	a_pos_dec: assert property (@(posedge pclk) disable iff (!presetn) // [R06]
		(step && !up && pos_q != QEI_ZERO && !pos_wr && !(idx_rise && !ctl_q.reset_mode))
		|=> pos_q == $past(pos_q) - QEI_ONE)
		else $error("position did not decrement");
	a_err_flag: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
		(ctl_q.enable && !ctl_q.signal_mode && both) |=> ris_q[QEI_INT_ERR])
		else $error("phase error not flagged");
	a_tmr_reload: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
		(ctl_q.enable && ctl_q.velocity_enable && tmr_q == QEI_ZERO)
		|=> tmr_q == $past(load_q) && cnt_q == QEI_ZERO)
		else $error("timer did not reload");
	a_tmr_count: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
		(ctl_q.enable && ctl_q.velocity_enable && tmr_q != QEI_ZERO)
		|=> tmr_q == $past(tmr_q) - QEI_ONE)
		else $error("timer did not count down");
	a_spd_copy: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		(ctl_q.enable && ctl_q.velocity_enable && tmr_q == QEI_ZERO && !step)
		|=> spd_q == $past(cnt_q))
		else $error("period total not captured");
	a_div_pass: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
		(ctl_q.enable && ctl_q.velocity_enable && ctl_q.velocity_predivide == 3'h0 && step
		&& tmr_q != QEI_ZERO) |=> cnt_q == $past(cnt_q) + QEI_ONE)
		else $error("undivided edge not counted");
	// Output must track the visible status, not a private copy
	a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
		irq == |(ris_q & inten_q))
		else $error("interrupt output wrong");
endmodule : qei_core

/* File: verif/qei_enc_model.sv */
// Purpose: Encoder wheel model with index channel
// Assumes: One step per go pulse, bench spaces steps
// Notes: Clock/direction step pulse lasts four cycles
`timescale 1ns/1ns
module qei_enc_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic back,
	input wire logic cdir,
	input wire logic err,
	input wire logic idx,
	output qei_pkg::qei_pins_t pins
);
	import qei_pkg::*;
	// ****************************************
	// Phase generation
	// ****************************************
	logic [1:0] ph_q;
	logic [1:0] ph_d;
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	always_comb begin
		ph_d = ph_q;
		cnt_d = cnt_q;
		if (cdir) begin
			if (cnt_q != 3'h0) cnt_d = cnt_q - 3'h1;
			else if (go) cnt_d = 3'h4;
			ph_d[1] = (cnt_d != 3'h0);
			// Direction only moves while idle, never on the clock edge
			if (cnt_q == 3'h0 && !go) ph_d[0] = ~back;
		end else if (err) begin
			ph_d = ~ph_q;
		end else if (go) begin
			// Gray order 00,10,11,01 forward, a leads b
			ph_d = back ? {ph_q[0], ~ph_q[1]} : {~ph_q[0], ph_q[1]};
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_q <= 2'h0;
			cnt_q <= 3'h0;
		end else begin
			ph_q <= ph_d;
			cnt_q <= cnt_d;
		end
	end
	assign pins = '{phase_a: ph_q[1], phase_b: ph_q[0], index: idx};
endmodule : qei_enc_model

/* File: verif/tb_top.sv */
// Purpose: Self-checking bench for the encoder block
// Assumes: APB answers with pready, reads noted in a queue
// Notes: Spurious edges after mode changes are cleared by a position write
`timescale 1ns/1ns
module tb_top;
	import qei_pkg::*;
	// ****************************************
	// Bench state
	// ****************************************
	logic pclk;
	logic presetn;
	qei_apb_req_t req;
	qei_apb_rsp_t rsp;
	qei_pins_t pins;
	logic irq;
	logic direction;
	logic go;
	logic back;
	logic cdir;
	logic err;
	logic idx;
	int fails;
	int cmp_count;
	int n;
	logic [31:0] mk;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	qei_core dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.pins(pins), .irq(irq), .direction(direction));
	qei_enc_model enc_u (.pclk(pclk), .presetn(presetn), .go(go), .back(back),
		.cdir(cdir), .err(err), .idx(idx), .pins(pins));
	task conclude;
		$display("Comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
		int i;
		if (!w) begin
			exp_q.push_back(d & m);
			msk_q.push_back(m);
		end
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		// Wait for pready, bounded so a dead slave cannot hang the run
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (rsp.pready === 1'b1) break;
		end
		if (i == 20) begin
			fails++;
			conclude();
		end
		req <= '0;
	endtask : apb
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'hFFFFFFFF);
	endtask : wr
	task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
		apb(1'b0, a, e, m);
	endtask : rd
	task step(input int k, input logic b);
		back <= b;
		repeat (2) @(posedge pclk);
		repeat (k) begin
			go <= 1'b1;
			@(posedge pclk);
			go <= 1'b0;
			repeat (7) @(posedge pclk);
		end
	endtask : step
	// One-cycle pulse on index when on_idx is set, else on the phase error strobe
	task pulse(input logic on_idx);
		idx <= on_idx;
		err <= !on_idx;
		@(posedge pclk);
		idx <= 1'b0;
		err <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask : pulse
	always @(posedge pclk) begin
		if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1 && exp_q.size() > 0) begin
			mk = msk_q.pop_front();
			check("prdata", rsp.prdata & mk, exp_q.pop_front());
		end
	end
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		presetn = 1'b0;
		req = '0;
		{go, back, cdir, err, idx} = 5'h00;
		n = $urandom(49661);
		n = $urandom_range(8, 1);
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(QEI_OFF_POS, 32'h0);
		rd(QEI_OFF_SPEED, 32'h0);
		rd(QEI_OFF_RIS, 32'h0);
		wr(QEI_OFF_MAXPOS, 32'h9);
		step(2, 1'b0);
		rd(QEI_OFF_POS, 32'h0);
		wr(QEI_OFF_CTL, 32'h9);
		step(n, 1'b0);
		rd(QEI_OFF_POS, n);
		wr(QEI_OFF_INTEN, 32'h2);
		step(n + 1, 1'b0 + 1'b1);
		rd(QEI_OFF_POS, 32'h9);
		rd(QEI_OFF_RIS, 32'h2, 32'h2);
		check("irq", 32'(irq), 32'h1);
		check("direction", 32'(direction), 32'h1);
		wr(QEI_OFF_ISC, 32'h2);
		rd(QEI_OFF_RIS, 32'h0, 32'h2);
		check("irq", 32'(irq), 32'h0);
		wr(QEI_OFF_POS, 32'h5);
		pulse(1'b1);
		rd(QEI_OFF_POS, 32'h0);
		rd(QEI_OFF_RIS, 32'h8, 32'h8);
		wr(QEI_OFF_CTL, 32'h19);
		wr(QEI_OFF_POS, 32'h5);
		pulse(1'b1);
		rd(QEI_OFF_POS, 32'h5);
		wr(QEI_OFF_CTL, 32'h1);
		wr(QEI_OFF_POS, 32'h0);
		step(4, 1'b0);
		rd(QEI_OFF_POS, 32'h2);
		wr(QEI_OFF_CTL, 32'hB);
		wr(QEI_OFF_POS, 32'h4);
		step(2, 1'b0);
		rd(QEI_OFF_POS, 32'h2);
		wr(QEI_OFF_CTL, 32'h209);
		wr(QEI_OFF_POS, 32'h4);
		step(2, 1'b0);
		rd(QEI_OFF_POS, 32'h2);
		wr(QEI_OFF_CTL, 32'h9);
		pulse(1'b0);
		rd(QEI_OFF_RIS, 32'h1, 32'h1);
		rd(QEI_OFF_STAT, 32'h1, 32'h1);
		wr(QEI_OFF_CTL, 32'h5);
		cdir <= 1'b1;
		repeat (8) @(posedge pclk);
		wr(QEI_OFF_POS, 32'h0);
		step(3, 1'b0);
		rd(QEI_OFF_POS, 32'h3);
		step(1, 1'b1);
		rd(QEI_OFF_POS, 32'h2);
		wr(QEI_OFF_LOAD, 32'h14);
		wr(QEI_OFF_CTL, 32'h20);
		wr(QEI_OFF_ISC, 32'h4);
		repeat (60) @(posedge pclk);
		rd(QEI_OFF_RIS, 32'h0, 32'h4);
		wr(QEI_OFF_CTL, 32'h25);
		repeat (60) @(posedge pclk);
		rd(QEI_OFF_RIS, 32'h4, 32'h4);
		rd(QEI_OFF_ISC, 32'h0, 32'h4);
		// Long period so the whole burst lands in one window
		wr(QEI_OFF_LOAD, 32'h200);
		repeat (25) @(posedge pclk);
		step(n, 1'b0);
		rd(QEI_OFF_COUNT, n);
		repeat (500) @(posedge pclk);
		rd(QEI_OFF_SPEED, n);
		rd(QEI_OFF_COUNT, 32'h0);
		wr(QEI_OFF_CTL, 32'hA5);
		step(8, 1'b0);
		rd(QEI_OFF_COUNT, 32'h2);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(QEI_OFF_SPEED, 32'h0);
		rd(QEI_OFF_CTL, 32'h0);
		conclude();
	end
endmodule : tb_top
